// ---- include/pmc_pkg.sv ----
// Package of types and constants for the power mode and clock fail-safe block.
// What this block does
// - Monitor enabled keeps low-power RC running, except Sleep.
// - Clock failure raises trap, switches to fast RC.
// - Fallback fast RC uses PLL if PLL active.
// - Power-save instruction operand selects Sleep or Idle.
// - Sleep halts core and stops system oscillator.
// - Idle halts core, system clock keeps running.
// - Monitor inactive in Sleep, reports no failure.
// - Watchdog enabled keeps low-power RC through Sleep.
// - Watchdog count cleared before Sleep takes effect.
// - Sleep disables system-clocked peripherals.
// - Sleep exits on interrupt, reset, watchdog time-out.
// - Sleep wake restarts on the entry clock source.
// - Idle entry clears the watchdog count.
// - Idle keeps low-power RC if watchdog or monitor.
// - Idle exits on interrupt, reset, watchdog time-out.
// - Idle wake resumes core after two to four cycles.
// - Unlocked next oscillator selection is honoured.
// - Interrupt during entry deferred, then wakes device.
package pmc_pkg;

   // ---------------------------------------------------------------
   // Oscillator source codes.
   // ---------------------------------------------------------------
   localparam logic [2:0] PMC_OSC_FRC = 3'h0;     // Fast RC oscillator.
   localparam logic [2:0] PMC_OSC_FRC_PLL = 3'h1; // Fast RC through the PLL.
   localparam logic [2:0] PMC_OSC_PRI = 3'h2;     // Primary oscillator.
   localparam logic [2:0] PMC_OSC_PRI_PLL = 3'h3; // Primary through the PLL.
   localparam logic [2:0] PMC_OSC_RESET = 3'h0;   // Source after reset.

   // ---------------------------------------------------------------
   // Timing constants.
   // ---------------------------------------------------------------
   localparam int PMC_CLK_PERIOD_NS = 10;   // Period of clk in ns.
   localparam int PMC_IDLE_WAKE_NS = 20;    // Least delay from Idle wake to run.
   localparam int PMC_IDLE_WAKE_CYC = (PMC_IDLE_WAKE_NS + PMC_CLK_PERIOD_NS - 1)
                                      / PMC_CLK_PERIOD_NS; // Rounded up.
   localparam logic [1:0] PMC_WAKE_CNT_INIT = 2'(PMC_IDLE_WAKE_CYC); // Counter load.

   // Power-save operand codes.
   localparam logic PMC_OP_SLEEP = 1'b0;  // Operand selecting Sleep.
   localparam logic PMC_OP_IDLE = 1'b1;   // Operand selecting Idle.

   // Power modes.
   typedef enum logic [2:0] {
      PMC_RUN,
      PMC_ENTER_SLEEP,
      PMC_SLEEP,
      PMC_ENTER_IDLE,
      PMC_IDLE,
      PMC_WAKE
   } pmc_mode_e;

   // Clock gating outputs travelling together.
   typedef struct packed {
      logic core_clk_en;    // Core clock running.
      logic periph_clk_en;  // System-clocked peripherals running.
      logic sys_osc_en;     // System oscillator powered.
      logic low_power_rc_osc_en;        // Low-power RC oscillator powered.
   } pmc_gate_s;

   // Wake sources travelling together.
   typedef struct packed {
      logic irq;         // Enabled interrupt pending.
      logic wdt_timeout; // Watchdog time-out.
   } pmc_wake_s;

endpackage

// ---- rtl/pmc_clk_mon.sv ----
// Clock failure detector: checks system clock edges against the low-power RC reference.
`timescale 1ns/1ps
module pmc_clk_mon
   import pmc_pkg::*;
(
   clk,
   rst_n,
   enable,
   sys_clk_in,
   ref_clk_in,
   fail
);
   input wire logic clk;        // Block clock.
   input wire logic rst_n;      // Synchronised reset, active low.
   input wire logic enable;     // Monitor is armed.
   input wire logic sys_clk_in; // Monitored clock, from a pin.
   input wire logic ref_clk_in; // Reference clock, from a pin.
   output logic fail;           // One-cycle failure pulse.

   // ---------------------------------------------------------------
   // State of the detector.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] sys_sync;  // Two-stage synchroniser for the monitored clock.
      logic [1:0] ref_sync;  // Two-stage synchroniser for the reference.
      logic sys_prev;        // Previous synchronised monitored level.
      logic ref_prev;        // Previous synchronised reference level.
      logic seen;            // A monitored edge arrived this reference period.
      logic fail;            // Failure pulse.
   } pmc_mon_s;

   pmc_mon_s st_r;
   pmc_mon_s st_nxt;

   // Next-state logic: a reference rising edge closes a period.
   always_comb begin
      st_nxt = st_r;
      st_nxt.sys_sync = {st_r.sys_sync[0], sys_clk_in};
      st_nxt.ref_sync = {st_r.ref_sync[0], ref_clk_in};
      st_nxt.sys_prev = st_r.sys_sync[1];
      st_nxt.ref_prev = st_r.ref_sync[1];
      st_nxt.fail = 1'b0;
      if (st_r.sys_sync[1] != st_r.sys_prev) begin
         st_nxt.seen = 1'b1;
      end
      if (!enable) begin
         // Disarmed, for example in Sleep: never report.
         st_nxt.seen = 1'b0;
      end else if (st_r.ref_sync[1] && !st_r.ref_prev) begin
         // No monitored edge during a whole reference period is a failure.
         st_nxt.fail = !st_r.seen;
         st_nxt.seen = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fail = st_r.fail;

   // Failure is only ever reported while armed.
   property p_mon_quiet;
      @(posedge clk) disable iff (!rst_n) !$past(enable) |-> !fail;
   endproperty
   a_mon_quiet: assert property (p_mon_quiet) else $error("monitor failed while off");
endmodule

// ---- rtl/pmc_top.sv ----
// Power mode sequencer and clock fail-safe controller.
`timescale 1ns/1ps
module pmc_top
   import pmc_pkg::*;
(
   clk,
   resetn,
   pwrsave_exec,
   pwrsave_operand,
   wake_in,
   clock_failure_monitor_enable,
   wdt_enable,
   cfg_locked,
   next_osc_select,
   osc_switch_req,
   pll_active,
   sys_clk_in,
   ref_clk_in,
   gate,
   cur_osc,
   wdt_clear,
   clock_fail_trap,
   core_resume,
   mode_sleep,
   mode_idle
);
   input wire logic clk;                   // 100 MHz clock.
   input wire logic resetn;                // Asynchronous reset, active low.
   input wire logic pwrsave_exec;          // Core executes the power-save instruction.
   input wire logic pwrsave_operand;       // Operand: sleep or idle.
   input wire pmc_pkg::pmc_wake_s wake_in; // Wake sources.
   input wire logic clock_failure_monitor_enable;           // Clock failure monitor enabled.
   input wire logic wdt_enable;            // Watchdog enabled.
   input wire logic cfg_locked;            // Clock configuration locked.
   input wire logic [2:0] next_osc_select; // Requested oscillator source.
   input wire logic osc_switch_req;        // Request to apply the selection.
   input wire logic pll_active;            // PLL scales the current clock.
   input wire logic sys_clk_in;            // Monitored system clock.
   input wire logic ref_clk_in;            // Low-power RC reference clock.
   output pmc_pkg::pmc_gate_s gate;        // Clock and oscillator enables.
   output logic [2:0] cur_osc;             // Current oscillator source.
   output logic wdt_clear;                 // Watchdog count clear pulse.
   output logic clock_fail_trap;           // Clock failure trap pulse.
   output logic core_resume;               // Core resumes after Idle, pulse.
   output logic mode_sleep;                // In Sleep.
   output logic mode_idle;                 // In Idle.

   // ---------------------------------------------------------------
   // Reset release and state.
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_r; // Reset release synchroniser.
   logic rst_n;            // Synchronised reset.

   // All state of the sequencer.
   typedef struct packed {
      pmc_mode_e mode;      // Power mode.
      logic [2:0] osc;      // Current oscillator source.
      logic [2:0] sleep_osc; // Source held across Sleep.
      logic [1:0] wake_cnt; // Idle wake delay counter.
      logic wake_pend;      // Deferred wake from the entry cycle.
      logic wdt_clear;      // Watchdog clear pulse.
      logic trap;           // Trap pulse.
      logic resume;         // Resume pulse.
      logic [1:0] wake_sync_irq; // Synchroniser for interrupt.
      logic [1:0] wake_sync_wdt; // Synchroniser for watchdog time-out.
      pmc_gate_s gate;      // Registered gate outputs.
   } pmc_state_s;

   pmc_state_s st_r;
   pmc_state_s st_nxt;
   logic mon_fail;    // Failure pulse from the detector.
   logic mon_enable;  // Detector armed.
   logic wake_any;    // Synchronised wake request.

   // Two flip-flops release the reset synchronously.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // The detector runs only outside Sleep.
   assign mon_enable = clock_failure_monitor_enable && (st_r.mode != PMC_SLEEP)
                       && (st_r.mode != PMC_ENTER_SLEEP);

   // ---------------------------------------------------------------
   // Clock failure detector.
   // ---------------------------------------------------------------
   pmc_clk_mon u_mon (
      .clk(clk),
      .rst_n(rst_n),
      .enable(mon_enable),
      .sys_clk_in(sys_clk_in),
      .ref_clk_in(ref_clk_in),
      .fail(mon_fail)
   );

   assign wake_any = st_r.wake_sync_irq[1] || st_r.wake_sync_wdt[1];

   // ---------------------------------------------------------------
   // Sequencer next-state logic.
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.wake_sync_irq = {st_r.wake_sync_irq[0], wake_in.irq};
      st_nxt.wake_sync_wdt = {st_r.wake_sync_wdt[0], wake_in.wdt_timeout};
      st_nxt.wdt_clear = 1'b0;
      st_nxt.trap = 1'b0;
      st_nxt.resume = 1'b0;
      // Software selection, only while unlocked and running.
      if (osc_switch_req && !cfg_locked && st_r.mode == PMC_RUN) begin
         st_nxt.osc = next_osc_select;
      end
      // Failure moves to fast RC, through the PLL if it was in use.
      if (mon_fail) begin
         st_nxt.trap = 1'b1;
         st_nxt.osc = pll_active ? PMC_OSC_FRC_PLL : PMC_OSC_FRC;
      end
      case (st_r.mode)
         PMC_RUN: begin
            if (pwrsave_exec) begin
               // Operand picks the mode; watchdog is cleared on entry.
               st_nxt.mode = (pwrsave_operand == PMC_OP_SLEEP) ? PMC_ENTER_SLEEP
                             : PMC_ENTER_IDLE;
               st_nxt.wdt_clear = wdt_enable;
               st_nxt.wake_pend = 1'b0;
            end
         end
         PMC_ENTER_SLEEP: begin
            // Entry completes first; a coincident wake is held.
            st_nxt.sleep_osc = st_r.osc;
            st_nxt.wake_pend = wake_any;
            st_nxt.mode = PMC_SLEEP;
         end
         PMC_ENTER_IDLE: begin
            st_nxt.wake_pend = wake_any;
            st_nxt.mode = PMC_IDLE;
         end
         PMC_SLEEP: begin
            if (wake_any || st_r.wake_pend) begin
               // Restart on the entry source.
               st_nxt.osc = st_r.sleep_osc;
               st_nxt.mode = PMC_RUN;
               st_nxt.wake_pend = 1'b0;
            end
         end
         PMC_IDLE: begin
            if (wake_any || st_r.wake_pend) begin
               st_nxt.mode = PMC_WAKE;
               st_nxt.wake_cnt = PMC_WAKE_CNT_INIT;
               st_nxt.wake_pend = 1'b0;
            end
         end
         PMC_WAKE: begin
            // Core clock is back; count down before resuming.
            if (st_r.wake_cnt <= 2'h1) begin
               st_nxt.mode = PMC_RUN;
               st_nxt.resume = 1'b1;
            end else begin
               st_nxt.wake_cnt = st_r.wake_cnt - 2'h1;
            end
         end
         default: begin
            st_nxt.mode = PMC_RUN;
         end
      endcase
      // Gates follow the next mode.
      st_nxt.gate.core_clk_en = (st_nxt.mode == PMC_RUN) || (st_nxt.mode == PMC_WAKE)
                                || (st_nxt.mode == PMC_ENTER_SLEEP)
                                || (st_nxt.mode == PMC_ENTER_IDLE);
      st_nxt.gate.periph_clk_en = (st_nxt.mode != PMC_SLEEP);
      st_nxt.gate.sys_osc_en = (st_nxt.mode != PMC_SLEEP);
      if (st_nxt.mode == PMC_SLEEP) begin
         st_nxt.gate.low_power_rc_osc_en = wdt_enable;
      end else begin
         st_nxt.gate.low_power_rc_osc_en = wdt_enable || clock_failure_monitor_enable;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{mode: PMC_RUN, osc: PMC_OSC_RESET, sleep_osc: PMC_OSC_RESET,
                   wake_cnt: 2'h0, wake_pend: 1'b0, wdt_clear: 1'b0, trap: 1'b0,
                   resume: 1'b0, wake_sync_irq: 2'h0, wake_sync_wdt: 2'h0,
                   gate: '{core_clk_en: 1'b1, periph_clk_en: 1'b1,
                           sys_osc_en: 1'b1, low_power_rc_osc_en: 1'b0}};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs.
   // ---------------------------------------------------------------
   assign gate = st_r.gate;
   assign cur_osc = st_r.osc;
   assign wdt_clear = st_r.wdt_clear;
   assign clock_fail_trap = st_r.trap;
   assign core_resume = st_r.resume;
   assign mode_sleep = (st_r.mode == PMC_SLEEP);
   assign mode_idle = (st_r.mode == PMC_IDLE);

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   sequence s_idle_wake;
      mode_idle && wake_any;
   endsequence

   property p_sleep_gates;
      @(posedge clk) disable iff (!rst_n) mode_sleep |-> !gate.sys_osc_en && !gate.core_clk_en;
   endproperty
   a_sleep_gates: assert property (p_sleep_gates) else $error("sleep left clocks on");

   property p_idle_periph;
      @(posedge clk) disable iff (!rst_n) mode_idle |-> gate.periph_clk_en && !gate.core_clk_en;
   endproperty
   a_idle_periph: assert property (p_idle_periph) else $error("idle gating wrong");

   property p_low_power_rc_osc_sleep;
      @(posedge clk) disable iff (!rst_n) mode_sleep && $past(wdt_enable) |-> gate.low_power_rc_osc_en;
   endproperty
   a_low_power_rc_osc_sleep: assert property (p_low_power_rc_osc_sleep) else $error("low_power_rc_osc off in sleep");

   property p_low_power_rc_osc_run;
      @(posedge clk) disable iff (!rst_n)
         !mode_sleep && $past(!mode_sleep) && $past(clock_failure_monitor_enable) && $past(rst_n)
         |-> gate.low_power_rc_osc_en;
   endproperty
   a_low_power_rc_osc_run: assert property (p_low_power_rc_osc_run) else $error("low_power_rc_osc off with monitor");

   property p_entry_clear;
      @(posedge clk) disable iff (!rst_n)
         st_r.mode == PMC_RUN && pwrsave_exec && wdt_enable |=> wdt_clear;
   endproperty
   a_entry_clear: assert property (p_entry_clear) else $error("watchdog not cleared");

   property p_trap_frc;
      @(posedge clk) disable iff (!rst_n)
         mon_fail && !pll_active |=> clock_fail_trap && cur_osc == PMC_OSC_FRC;
   endproperty
   a_trap_frc: assert property (p_trap_frc) else $error("no fallback to fast RC");

   property p_trap_pll;
      @(posedge clk) disable iff (!rst_n)
         mon_fail && pll_active |=> cur_osc == PMC_OSC_FRC_PLL;
   endproperty
   a_trap_pll: assert property (p_trap_pll) else $error("fallback lost the PLL");

   property p_idle_resume;
      @(posedge clk) disable iff (!rst_n) s_idle_wake |-> ##[2:4] core_resume;
   endproperty
   a_idle_resume: assert property (p_idle_resume) else $error("idle resume late");

   property p_sleep_osc;
      @(posedge clk) disable iff (!rst_n)
         mode_sleep && wake_any |=> !mode_sleep && cur_osc == $past(st_r.sleep_osc);
   endproperty
   a_sleep_osc: assert property (p_sleep_osc) else $error("wrong source after sleep");

   property p_no_fail_sleep;
      @(posedge clk) disable iff (!rst_n) mode_sleep |-> !mon_fail;
   endproperty
   a_no_fail_sleep: assert property (p_no_fail_sleep) else $error("failure in sleep");
endmodule

// ---- tb/pmc_osc_model.sv ----
// Behavioural model of the oscillator sources that feed the monitor inputs.
`timescale 1ns/1ps
module pmc_osc_model
   import pmc_pkg::*;
(
   clk,
   gate,
   osc_dead,
   sys_clk_out,
   ref_clk_out
);
   input wire logic clk;               // Block clock.
   input wire pmc_pkg::pmc_gate_s gate; // Oscillator enables from the block.
   input wire logic osc_dead;          // Bench command: the system oscillator fails.
   output logic sys_clk_out;           // System oscillator, period of 8 clk.
   output logic ref_clk_out;           // Low-power RC, period of 64 clk.
   logic [4:0] div_r;                  // Free divider for both sources.
   initial begin
      div_r = 5'h00;
      sys_clk_out = 1'b0;
      ref_clk_out = 1'b0;
   end
   // A stopped oscillator holds its level, as a real source does.
   always @(posedge clk) begin
      div_r <= div_r + 5'h01;
      if (gate.sys_osc_en && !osc_dead && div_r[1:0] == 2'h3) begin
         sys_clk_out <= ~sys_clk_out;
      end
      if (gate.low_power_rc_osc_en && div_r == 5'h1f) begin
         ref_clk_out <= ~ref_clk_out;
      end
   end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the power mode and clock fail-safe block.
`timescale 1ns/1ps
module testbench;
   import pmc_pkg::*;
   logic clk, resetn, pwrsave_exec, pwrsave_operand, clock_failure_monitor_enable, wdt_enable;
   logic cfg_locked, osc_switch_req, pll_active, sys_clk_in, ref_clk_in, osc_dead;
   logic [2:0] next_osc_select, cur_osc, exp_osc;
   logic wdt_clear, clock_fail_trap, core_resume, mode_sleep, mode_idle, seen;
   pmc_wake_s wake_in;
   pmc_gate_s gate;
   int n_errors, cmp_count, seed, i, j, n, nclr;
   pmc_top uut (.clk(clk), .resetn(resetn), .pwrsave_exec(pwrsave_exec),
      .pwrsave_operand(pwrsave_operand), .wake_in(wake_in), .clock_failure_monitor_enable(clock_failure_monitor_enable),
      .wdt_enable(wdt_enable), .cfg_locked(cfg_locked), .next_osc_select(next_osc_select),
      .osc_switch_req(osc_switch_req), .pll_active(pll_active), .sys_clk_in(sys_clk_in),
      .ref_clk_in(ref_clk_in), .gate(gate), .cur_osc(cur_osc), .wdt_clear(wdt_clear),
      .clock_fail_trap(clock_fail_trap), .core_resume(core_resume),
      .mode_sleep(mode_sleep), .mode_idle(mode_idle));
   pmc_osc_model osc (.clk(clk), .gate(gate), .osc_dead(osc_dead),
      .sys_clk_out(sys_clk_in), .ref_clk_out(ref_clk_in));
   always #5 clk = ~clk;
   // Expected enables for mode m: 0 run, 1 sleep, 2 idle.
   function automatic pmc_gate_s exp_gate(input int m, input logic w, input logic f);
      pmc_gate_s g;
      g.core_clk_en = (m == 0);
      g.periph_clk_en = (m != 1);
      g.sys_osc_en = (m != 1);
      g.low_power_rc_osc_en = (m == 1) ? w : (w | f);
      return g;
   endfunction
   task automatic check(input bit ok, input string msg);
      cmp_count++;
      if (!ok) begin
         $display("wrong value at %0t: %s", $time, msg);
         n_errors++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Issues one power-save instruction and counts clear pulses and mode entry.
   task automatic pwrsave(input logic op);
      pwrsave_exec = 1'b1;
      pwrsave_operand = op;
      nclr = 0;
      seen = 1'b0;
      for (int k = 0; k < 6; k++) begin
         @(negedge clk);
         pwrsave_exec = 1'b0;
         if (wdt_clear === 1'b1) nclr++;
         if ((op ? mode_idle : mode_sleep) === 1'b1) seen = 1'b1;
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
   initial begin
      seed = 32'hf40ba970;
      clk = 1'b0; resetn = 1'b0; pwrsave_exec = 1'b0; pwrsave_operand = 1'b0;
      wake_in = '0; clock_failure_monitor_enable = 1'b0; wdt_enable = 1'b0; cfg_locked = 1'b0;
      next_osc_select = 3'h0; osc_switch_req = 1'b0; pll_active = 1'b0; osc_dead = 1'b0;
      n_errors = 0; cmp_count = 0; exp_osc = PMC_OSC_RESET;
      cyc(12);
      check(gate === 4'he && cur_osc === PMC_OSC_RESET, "reset values");
      resetn = 1'b1;
      clock_failure_monitor_enable = 1'b1;
      cyc(5);
      check(gate === exp_gate(0, 1'b0, 1'b1), "run enables");
      // Source selection, unlocked and locked.
      for (i = 0; i < 8; i++) begin
         next_osc_select = 3'(i % 4);
         cfg_locked = (i < 4) ? 1'b0 : 1'($random(seed));
         osc_switch_req = 1'b1;
         cyc(1);
         osc_switch_req = 1'b0;
         cyc(1);
         if (!cfg_locked) exp_osc = next_osc_select;
         check(cur_osc === exp_osc, "source select");
      end
      cfg_locked = 1'b0;
      // Sleep, woken by each source in turn; the monitor stays enabled at first, though the detector is disarmed in Sleep.
      for (j = 0; j < 2; j++) begin
         wdt_enable = (j == 0) ? 1'b1 : 1'($random(seed));
         pwrsave(PMC_OP_SLEEP);
         check(nclr == int'(wdt_enable) && seen, "sleep entry");
         check(gate === exp_gate(1, wdt_enable, clock_failure_monitor_enable), "sleep gates");
         n = 0;
         for (i = 0; i < 150; i++) begin
            @(negedge clk);
            if (clock_fail_trap === 1'b1) n++;
         end
         check(n == 0 && mode_sleep === 1'b1, "no trap in sleep");
         clock_failure_monitor_enable = 1'b0;
         if (j == 0) wake_in.irq = 1'b1;
         else wake_in.wdt_timeout = 1'b1;
         for (i = 0; i < 10 && mode_sleep !== 1'b0; i++) @(negedge clk);
         wake_in = '0;
         check(mode_sleep === 1'b0 && cur_osc === exp_osc, "sleep wake");
         cyc(2);
         check(gate === exp_gate(0, wdt_enable, 1'b0), "gates after sleep");
      end
      // Idle with random watchdog and monitor enables.
      for (j = 0; j < 2; j++) begin
         wdt_enable = 1'($random(seed));
         clock_failure_monitor_enable = 1'($random(seed));
         pwrsave(PMC_OP_IDLE);
         check(nclr == int'(wdt_enable) && seen, "idle entry");
         check(gate === exp_gate(2, wdt_enable, clock_failure_monitor_enable), "idle gates");
         if (j == 0) wake_in.irq = 1'b1;
         else wake_in.wdt_timeout = 1'b1;
         for (i = 0; i < 10 && gate.core_clk_en !== 1'b1; i++) @(negedge clk);
         wake_in = '0;
         for (n = 0; n < 8 && core_resume !== 1'b1; n++) @(negedge clk);
         check(n >= 2 && n <= 4 && mode_idle === 1'b0, "idle resume delay");
         clock_failure_monitor_enable = 1'b0;
         cyc(3);
      end
      // Interrupt coincident with the instruction is deferred, then wakes.
      wake_in.irq = 1'b1;
      pwrsave(PMC_OP_IDLE);
      for (i = 0; i < 10 && mode_idle !== 1'b0; i++) @(negedge clk);
      wake_in = '0;
      check(seen && mode_idle === 1'b0, "deferred interrupt");
      cyc(4);
      // Oscillator failure, without and with the PLL.
      for (j = 0; j < 2; j++) begin
         pll_active = 1'(j);
         clock_failure_monitor_enable = 1'b1;
         cyc(140);
         osc_dead = 1'b1;
         for (i = 0; i < 200 && clock_fail_trap !== 1'b1; i++) @(negedge clk);
         check(clock_fail_trap === 1'b1, "failure trap");
         clock_failure_monitor_enable = 1'b0;
         osc_dead = 1'b0;
         exp_osc = j ? PMC_OSC_FRC_PLL : PMC_OSC_FRC;
         cyc(2);
         check(cur_osc === exp_osc, "fallback source");
      end
      // Disabled monitor stays silent on a dead oscillator.
      osc_dead = 1'b1;
      n = 0;
      for (i = 0; i < 200; i++) begin
         @(negedge clk);
         if (clock_fail_trap === 1'b1) n++;
      end
      check(n == 0, "disabled monitor");
      osc_dead = 1'b0;
      // Device reset wakes from Sleep.
      pwrsave(PMC_OP_SLEEP);
      resetn = 1'b0;
      cyc(2);
      check(mode_sleep === 1'b0 && gate === 4'he, "reset wake");
      resetn = 1'b1;
      cyc(5);
      give_verdict();
   end
endmodule
